/* File: gsc_consts.svh */
// register offsets, field positions, reset values and select codes
`ifndef GSC_CONSTS_SVH
`define GSC_CONSTS_SVH

`define GSC_ADDR_W 12
`define GSC_DATA_W 16

`define GSC_GENCFG_ADDR 12'h001
`define GSC_EXTSYNC_ADDR 12'h002

`define GSC_BIT_OSC_LOAD 0
`define GSC_BIT_CNT_LOAD 1
`define GSC_BIT_QUEUE_RST 2
`define GSC_BIT_DELAY_LO 3
`define GSC_BIT_DELAY_HI 6
`define GSC_BIT_PATTERN 7
`define GSC_BIT_VER_LO 8
`define GSC_BIT_VER_HI 11
`define GSC_BIT_SPARE_LO 12
`define GSC_BIT_SPARE_HI 13

`define GSC_RSVD_READ 2'b10
`define GSC_DELAY_RESET 4'h0
`define GSC_SPARE_RESET 2'b00

`define GSC_BIT_EN_LO 0
`define GSC_BIT_EN_HI 4
`define GSC_BIT_SEL_LO 5
`define GSC_BIT_SEL_HI 9
`define GSC_EXT_EN_RESET 5'h0f
`define GSC_SEL_RESET 5'h00

`define GSC_SEL_HIZ 5'h00
`define GSC_SEL_DCLK16 5'h01
`define GSC_SEL_RELEASE 5'h02
`define GSC_SEL_PIN 5'h03
`define GSC_SEL_MISR 5'h04
`define GSC_SEL_DLL 5'h05
`define GSC_STROBE_COUNT 16

`endif

/* File: gsc_pkg.sv */
// types shared by the global sync control block
package gsc_pkg;

  typedef struct packed {
    logic pattern;
    logic queue_reset;
    logic counter_load;
    logic oscillator_load;
  } gsc_pulse_t;

  typedef struct packed {
    logic sixth;
    logic fifth;
    logic fourth;
    logic third;
  } gsc_delay_t;

  // same order as the enable bits 4..0
  typedef struct packed {
    logic dataclock;
    logic pattern;
    logic oscillator;
    logic counter_load;
    logic queue_reset;
  } gsc_sync_set_t;

  typedef struct packed {
    logic [15:0] fifo_read_strobe;
    logic dll_lock;
    logic misr_sample;
    logic fifo_release;
    logic data_clock_div_sixteen;
  } gsc_test_src_t;

  typedef struct packed {
    gsc_pulse_t pulse;
    gsc_delay_t delay;
    logic [1:0] spare;
    gsc_sync_set_t pin_en;
    logic [4:0] test_output_select;
    gsc_sync_set_t pin_ev;
    logic [15:0] rdata;
  } gsc_state_t;

endpackage

/* File: gsc_pin_sync.sv */
// two-flop synchroniser and rising-edge detect for the timing pulse pin
`timescale 1ns/1ns
module gsc_pin_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // pin
  input wire logic pin_raw,
  // synchronised view
  output logic synced_level,
  output logic rise
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } gsc_sync_state_t;

  gsc_sync_state_t state_q, state_d;

  always_comb begin
    state_d = state_q;
    state_d.meta = pin_raw;
    state_d.sync = state_q.meta;
    state_d.prev = state_q.sync;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign synced_level = state_q.sync;
  assign rise = state_q.sync & ~state_q.prev;

  AST_PIN_RISE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ($rose(pin_raw) ##1 pin_raw [*2]) |-> rise)
    else $error("held pin pulse gave no synchronised edge");

endmodule // gsc_pin_sync

/* File: gsc_test_mux.sv */
// registered selector for the digital test output pin
`timescale 1ns/1ns
`include "gsc_consts.svh"
module gsc_test_mux
  import gsc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // selection
  input wire logic [4:0] test_output_select,
  input wire logic synced_timing_pulse,
  input wire gsc_test_src_t test_src,
  // pin
  output logic test_pin_out,
  output logic test_pin_oe
);

  typedef struct packed {
    gsc_test_src_t meta;
    gsc_test_src_t sync;
    logic out;
    logic oe;
  } gsc_mux_state_t;

  gsc_mux_state_t state_q, state_d;

  always_comb begin
    state_d = state_q;
    state_d.meta = test_src;
    state_d.sync = state_q.meta;
    state_d.out = 1'b0;
    state_d.oe = 1'b1;
    unique case (test_output_select)
      `GSC_SEL_HIZ: state_d.oe = 1'b0;
      `GSC_SEL_DCLK16: state_d.out = state_q.sync.data_clock_div_sixteen;
      `GSC_SEL_RELEASE: state_d.out = state_q.sync.fifo_release;
      `GSC_SEL_PIN: state_d.out = synced_timing_pulse;
      `GSC_SEL_MISR: state_d.out = state_q.sync.misr_sample;
      `GSC_SEL_DLL: state_d.out = state_q.sync.dll_lock;
      default: begin
        if (test_output_select[4]) begin
          state_d.out = state_q.sync.fifo_read_strobe[test_output_select[3:0]];
        end else begin
          state_d.oe = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign test_pin_out = state_q.out;
  assign test_pin_oe = state_q.oe;

  AST_TEST_HIZ: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (test_output_select == `GSC_SEL_HIZ) |=> !test_pin_oe)
    else $error("test pin driven while high impedance selected");

  AST_TEST_DCLK: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (test_output_select == `GSC_SEL_DCLK16) |=>
      (test_pin_oe && test_pin_out == $past(state_q.sync.data_clock_div_sixteen)))
    else $error("test pin does not follow divided data clock");

  AST_TEST_STROBE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    test_output_select[4] |=>
      (test_pin_oe &&
       test_pin_out == $past(state_q.sync.fifo_read_strobe[test_output_select[3:0]])))
    else $error("test pin does not follow selected read strobe");

endmodule // gsc_test_mux

/* File: gsc_top.sv */
// global configuration and external sync control register bank
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`include "gsc_consts.svh"
module gsc_top
  import gsc_pkg::*;
#(
  // arbitrary values
  parameter logic [3:0] SILICON_VERSION = 4'h6,
  parameter logic [3:0] PREPROD_VERSION = 4'hf,
  parameter logic PRE_PRODUCTION = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [`GSC_ADDR_W-1:0] reg_addr,
  input wire logic [`GSC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`GSC_DATA_W-1:0] reg_rdata,
  // timing pulse pin
  input wire logic external_timing_pulse_pin,
  // test observation sources
  input wire gsc_test_src_t test_src,
  // test pin
  output logic test_pin_out,
  output logic test_pin_oe,
  // global pulses from software
  output gsc_pulse_t global_pulse,
  // delay stage enables
  output gsc_delay_t delay_enable,
  // pin sync events
  output gsc_sync_set_t pin_sync_event
);

  ////////////////////////////////////////////////////////////////////////////
  // decoding

  function automatic logic is_gencfg(input logic [`GSC_ADDR_W-1:0] addr);
    is_gencfg = (addr == `GSC_GENCFG_ADDR);
  endfunction

  function automatic logic is_extsync(input logic [`GSC_ADDR_W-1:0] addr);
    is_extsync = (addr == `GSC_EXTSYNC_ADDR);
  endfunction

  function automatic logic [3:0] reported_version(input logic pre);
    reported_version = pre ? PREPROD_VERSION : SILICON_VERSION;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  gsc_state_t state_q, state_d;
  logic wr_gen;
  logic wr_ext;
  logic rd_gen;
  logic rd_ext;
  logic synced_timing_pulse;
  logic pin_rise;

  assign wr_gen = reg_wr & is_gencfg(reg_addr);
  assign wr_ext = reg_wr & is_extsync(reg_addr);
  assign rd_gen = reg_rd & is_gencfg(reg_addr);
  assign rd_ext = reg_rd & is_extsync(reg_addr);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  gsc_pin_sync u_pin_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_raw(external_timing_pulse_pin),
    .synced_level(synced_timing_pulse),
    .rise(pin_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_d = state_q;
    // pulses last one cycle unless written again
    state_d.pulse = '0;
    if (wr_gen) begin
      state_d.pulse.pattern = reg_wdata[`GSC_BIT_PATTERN];
      state_d.pulse.queue_reset = reg_wdata[`GSC_BIT_QUEUE_RST];
      state_d.pulse.counter_load = reg_wdata[`GSC_BIT_CNT_LOAD];
      state_d.pulse.oscillator_load = reg_wdata[`GSC_BIT_OSC_LOAD];
      state_d.delay = reg_wdata[`GSC_BIT_DELAY_HI:`GSC_BIT_DELAY_LO];
      state_d.spare = reg_wdata[`GSC_BIT_SPARE_HI:`GSC_BIT_SPARE_LO];
    end
    if (wr_ext) begin
      state_d.pin_en = reg_wdata[`GSC_BIT_EN_HI:`GSC_BIT_EN_LO];
      state_d.test_output_select = reg_wdata[`GSC_BIT_SEL_HI:`GSC_BIT_SEL_LO];
    end
    // pin edge gated by each enable
    state_d.pin_ev.dataclock = pin_rise & state_q.pin_en.dataclock;
    state_d.pin_ev.pattern = pin_rise & state_q.pin_en.pattern;
    state_d.pin_ev.oscillator = pin_rise & state_q.pin_en.oscillator;
    state_d.pin_ev.counter_load = pin_rise & state_q.pin_en.counter_load;
    state_d.pin_ev.queue_reset = pin_rise & state_q.pin_en.queue_reset;
    // read data stands for one cycle only
    state_d.rdata = '0;
    if (rd_gen) begin
      state_d.rdata = {
        `GSC_RSVD_READ,
        state_q.spare,
        reported_version(PRE_PRODUCTION),
        1'b0,
        state_q.delay,
        3'b000
      };
    end else if (rd_ext) begin
      state_d.rdata = {
        6'h00,
        state_q.test_output_select,
        state_q.pin_en
      };
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q.pulse <= '0;
      state_q.delay <= `GSC_DELAY_RESET;
      state_q.spare <= `GSC_SPARE_RESET;
      state_q.pin_en <= `GSC_EXT_EN_RESET;
      state_q.test_output_select <= `GSC_SEL_RESET;
      state_q.pin_ev <= '0;
      state_q.rdata <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // test pin

  gsc_test_mux u_test_mux (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .test_output_select(state_q.test_output_select),
    .synced_timing_pulse(synced_timing_pulse),
    .test_src(test_src),
    .test_pin_out(test_pin_out),
    .test_pin_oe(test_pin_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata = state_q.rdata;
  assign global_pulse = state_q.pulse;
  assign delay_enable = state_q.delay;
  assign pin_sync_event = state_q.pin_ev;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_VERSION_READ: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    rd_gen |=>
      (reg_rdata[`GSC_BIT_VER_HI:`GSC_BIT_VER_LO] == reported_version(PRE_PRODUCTION)))
    else $error("version field reads wrong");

  AST_PREPROD_DISTINCT: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (rd_gen && PRE_PRODUCTION) |=>
      (reg_rdata[`GSC_BIT_VER_HI:`GSC_BIT_VER_LO] == PREPROD_VERSION))
    else $error("pre-production part reports a production version");

  AST_PATTERN_PULSE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    global_pulse.pattern == $past(wr_gen && reg_wdata[`GSC_BIT_PATTERN]))
    else $error("pattern sync pulse does not match write");

  AST_QUEUE_PULSE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (wr_gen && reg_wdata[`GSC_BIT_QUEUE_RST]) ##1 !wr_gen |=>
      (!global_pulse.queue_reset && $past(global_pulse.queue_reset)))
    else $error("queue reset pulse not a single cycle");

  AST_COUNTER_PULSE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    $rose(global_pulse.counter_load) |->
      $past(wr_gen && reg_wdata[`GSC_BIT_CNT_LOAD]))
    else $error("counter load pulse without a write");

  AST_OSC_PULSE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (wr_gen && reg_wdata[`GSC_BIT_OSC_LOAD]) |=> global_pulse.oscillator_load)
    else $error("oscillator load pulse missing");

  AST_DELAY_WRITE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wr_gen |=>
      (delay_enable == $past(reg_wdata[`GSC_BIT_DELAY_HI:`GSC_BIT_DELAY_LO])))
    else $error("delay enables not written");

  AST_DELAY_HOLD: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !wr_gen |=> $stable(delay_enable))
    else $error("delay enables changed without a write");

  AST_ZERO_NO_PULSE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !(wr_gen && reg_wdata[`GSC_BIT_OSC_LOAD]) |=> !global_pulse.oscillator_load)
    else $error("oscillator pulse without a written one");

  AST_PULSE_READS_ZERO: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    rd_gen |=>
      (reg_rdata[`GSC_BIT_PATTERN] == 1'b0 &&
       reg_rdata[`GSC_BIT_QUEUE_RST:`GSC_BIT_OSC_LOAD] == 3'b000))
    else $error("pulse bit reads back as one");

  AST_PIN_DATACLOCK: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    pin_sync_event.dataclock == $past(pin_rise && state_q.pin_en.dataclock))
    else $error("data clock re-align event wrong");

  AST_PIN_PATTERN: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (pin_rise && state_q.pin_en.pattern) |=> pin_sync_event.pattern)
    else $error("pattern sync from pin missing");

  AST_PIN_OSC: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (pin_rise && !state_q.pin_en.oscillator) |=> !pin_sync_event.oscillator)
    else $error("oscillator sync from pin while disabled");

  AST_PIN_COUNTER: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    pin_sync_event.counter_load |-> $past(pin_rise && state_q.pin_en.counter_load))
    else $error("counter load event without enabled pin edge");

  AST_PIN_QUEUE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ($rose(external_timing_pulse_pin) ##1 external_timing_pulse_pin [*2] ##0
     state_q.pin_en.queue_reset) |=> pin_sync_event.queue_reset)
    else $error("queue reset from pin missing");

  AST_EXT_READ: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wr_ext ##1 rd_ext |=>
      (reg_rdata[`GSC_BIT_SEL_HI:`GSC_BIT_SEL_LO] ==
       $past(reg_wdata[`GSC_BIT_SEL_HI:`GSC_BIT_SEL_LO], 2)))
    else $error("test select does not read back");

  AST_RDATA_IDLE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !reg_rd |=> (reg_rdata == 16'h0000))
    else $error("read data stands outside the read answer cycle");

  AST_QUEUE_WRITE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (wr_gen && reg_wdata[`GSC_BIT_QUEUE_RST]) |=> global_pulse.queue_reset)
    else $error("queue reset pulse missing");

  AST_COUNTER_WRITE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (wr_gen && reg_wdata[`GSC_BIT_CNT_LOAD]) |=> global_pulse.counter_load)
    else $error("counter load pulse missing");

  AST_PATTERN_SINGLE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (wr_gen && reg_wdata[`GSC_BIT_PATTERN]) ##1 !wr_gen |=> !global_pulse.pattern)
    else $error("pattern sync pulse longer than one cycle");

  AST_OSC_SINGLE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (global_pulse.oscillator_load && !wr_gen) |=> !global_pulse.oscillator_load)
    else $error("oscillator load pulse longer than one cycle");

  AST_ZERO_ALL: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !wr_gen |=> (global_pulse == '0))
    else $error("global pulse without a write");

  AST_EN_WRITE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wr_ext |=> (state_q.pin_en == $past(reg_wdata[`GSC_BIT_EN_HI:`GSC_BIT_EN_LO])))
    else $error("pin sync enables not written");

  AST_EN_HOLD: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !wr_ext |=> $stable(state_q.pin_en))
    else $error("pin sync enables changed without a write");

  AST_SEL_WRITE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wr_ext |=> (state_q.test_output_select == $past(reg_wdata[`GSC_BIT_SEL_HI:`GSC_BIT_SEL_LO])))
    else $error("test select not written");

  AST_EXT_READ_NOW: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    rd_ext |=>
      (reg_rdata == {6'h00, $past(state_q.test_output_select), $past(state_q.pin_en)}))
    else $error("external sync register reads wrong");

  AST_PIN_OSC_ON: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (pin_rise && state_q.pin_en.oscillator) |=> pin_sync_event.oscillator)
    else $error("oscillator sync from pin missing");

  AST_PIN_COUNTER_ON: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (pin_rise && state_q.pin_en.counter_load) |=> pin_sync_event.counter_load)
    else $error("counter load from pin missing");

  AST_PIN_PATTERN_OFF: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (pin_rise && !state_q.pin_en.pattern) |=> !pin_sync_event.pattern)
    else $error("pattern sync from pin while disabled");

  AST_PIN_QUEUE_OFF: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (pin_rise && !state_q.pin_en.queue_reset) |=> !pin_sync_event.queue_reset)
    else $error("queue reset from pin while disabled");

  AST_PIN_SINGLE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (pin_sync_event != '0) |=> (pin_sync_event == '0))
    else $error("pin sync event longer than one cycle");

endmodule // gsc_top

/* File: gsc_timing_source.sv */
// behavioural external timing source driving the sync pulse pin
`timescale 1ns/1ns
module gsc_timing_source (
  // clock
  input wire logic clk_sys,
  // pin
  output logic pulse_out
);
  // idle low between pulses
  initial pulse_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic send_pulse(input int hi_cycles);
    @(posedge clk_sys);
    pulse_out <= 1'b1;
    repeat (hi_cycles) @(posedge clk_sys);
    pulse_out <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
endmodule // gsc_timing_source

/* File: global_sync_control_bench.sv */
// self-checking bench for the global sync control register bank
`timescale 1ns/1ns
`include "gsc_consts.svh"
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module global_sync_control_bench
  import gsc_pkg::*;
;
  // arbitrary version values
  localparam logic [3:0] VER = 4'h5;
  localparam logic [3:0] PRE_VER = 4'h9;
  localparam logic [11:0] GCFG = `GSC_GENCFG_ADDR;
  localparam logic [11:0] XSYN = `GSC_EXTSYNC_ADDR;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [`GSC_ADDR_W-1:0] reg_addr = '0;
  logic [`GSC_DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [`GSC_DATA_W-1:0] reg_rdata;
  logic [`GSC_DATA_W-1:0] rdata_pre;
  gsc_test_src_t test_src = '0;
  logic pin_line;
  logic test_pin_out;
  logic test_pin_oe;
  gsc_pulse_t global_pulse;
  gsc_delay_t delay_enable;
  gsc_sync_set_t pin_sync_event;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  always #2 clk_sys = ~clk_sys;

  gsc_top #(.SILICON_VERSION(VER)) i_gsc_top (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .external_timing_pulse_pin(pin_line), .test_src(test_src),
    .test_pin_out(test_pin_out), .test_pin_oe(test_pin_oe), .global_pulse(global_pulse),
    .delay_enable(delay_enable), .pin_sync_event(pin_sync_event));
  // pre-production part beside it
  gsc_top #(.PREPROD_VERSION(PRE_VER), .PRE_PRODUCTION(1'b1)) i_gsc_top_pre (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_pre),
    .external_timing_pulse_pin(pin_line), .test_src(test_src), .test_pin_out(),
    .test_pin_oe(), .global_pulse(), .delay_enable(), .pin_sync_event());
  gsc_timing_source i_gsc_timing_source (.clk_sys(clk_sys), .pulse_out(pin_line));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] gcfg(input logic [1:0] spare, input logic [3:0] dly);
    return {`GSC_RSVD_READ, spare, VER, 1'b0, dly, 3'b000};
  endfunction

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHECK(reg_rdata, exp)
  endtask

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    `CHECK(global_pulse, 4'h0)
    `CHECK(delay_enable, 4'h0)
    `CHECK(test_pin_oe, 1'b0)
    rd_chk(GCFG, gcfg(2'b00, 4'h0));
    `CHECK(rdata_pre, {`GSC_RSVD_READ, 2'b00, PRE_VER, 8'h00})
    rd_chk(XSYN, 16'h000f);
  endtask

  task automatic t_pulses;
    int b[4] = '{0, 1, 2, 7};
    for (int i = 0; i < 4; i++) begin
      wr(GCFG, 16'h0001 << b[i]);
      `CHECK(global_pulse, 4'(4'h1 << i))
      @(posedge clk_sys);
      #1;
      `CHECK(global_pulse, 4'h0)
      rd_chk(GCFG, gcfg(2'b00, 4'h0));
    end
    wr(GCFG, 16'h0000);
    `CHECK(global_pulse, 4'h0)
    wr(12'h003, 16'h00ff);
    `CHECK(global_pulse, 4'h0)
    rd_chk(12'h003, 16'h0000);
    // back-to-back writes
    @(posedge clk_sys);
    reg_addr <= GCFG;
    reg_wdata <= 16'h0081;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wdata <= 16'h0004;
    #1;
    `CHECK(global_pulse, 4'h9)
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
    `CHECK(global_pulse, 4'h4)
    @(posedge clk_sys);
    #1;
    `CHECK(global_pulse, 4'h0)
  endtask

  task automatic t_pin_sync;
    gsc_sync_set_t seen;
    gsc_sync_set_t en;
    int hits;
    for (int i = 0; i < 7; i++) begin
      en = (i < 5) ? 5'(5'h1 << i) : ((i == 5) ? 5'h00 : 5'h1f);
      wr(XSYN, {11'h000, en});
      seen = '0;
      hits = 0;
      fork
        i_gsc_timing_source.send_pulse(3);
        repeat (12) begin
          @(posedge clk_sys);
          #1;
          seen |= pin_sync_event;
          if (pin_sync_event !== 5'h00) hits++;
        end
      join
      `CHECK(seen, en)
      `CHECK(hits, (en != 5'h00) ? 1 : 0)
      rd_chk(XSYN, {11'h000, en});
    end
  endtask

  task automatic t_back_to_back;
    // write then read with no gap
    @(posedge clk_sys);
    reg_addr <= XSYN;
    reg_wdata <= 16'h0215;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHECK(reg_rdata, 16'h0215)
    rd_chk(XSYN, 16'h0215);
  endtask

  task automatic t_test_pin;
    int hot;
    logic drv;
    logic oe_exp;
    for (int c = 0; c < 32; c++) begin
      wr(XSYN, {6'h00, 5'(c), 5'h00});
      hot = (c >= 16) ? c - 12 : ((c < 3) ? c - 1 : c - 2);
      drv = (c inside {1, 2, 4, 5}) || c >= 16;
      oe_exp = drv || c == 3;
      @(posedge clk_sys);
      test_src <= drv ? gsc_test_src_t'(20'h1 << hot) : '0;
      repeat (4) @(posedge clk_sys);
      #1;
      `CHECK(test_pin_oe, oe_exp)
      if (oe_exp) `CHECK(test_pin_out, drv)
      @(posedge clk_sys);
      test_src <= drv ? gsc_test_src_t'(~(20'h1 << hot)) : '0;
      repeat (4) @(posedge clk_sys);
      #1;
      if (oe_exp) `CHECK(test_pin_out, 1'b0)
    end
    wr(XSYN, {6'h00, `GSC_SEL_PIN, 5'h00});
    fork
      i_gsc_timing_source.send_pulse(6);
      begin
        repeat (5) @(posedge clk_sys);
        #1;
        `CHECK(test_pin_out, 1'b1)
      end
    join
    repeat (3) @(posedge clk_sys);
    #1;
    `CHECK(test_pin_out, 1'b0)
  endtask

  task automatic t_delay;
    wr(GCFG, 16'h0078);
    `CHECK(delay_enable, 4'hf)
    rd_chk(GCFG, gcfg(2'b00, 4'hf));
    wr(GCFG, 16'h3008);
    `CHECK(delay_enable, 4'h1)
    rd_chk(GCFG, gcfg(2'b11, 4'h1));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    t_reset();
    t_pulses();
    t_pin_sync();
    t_test_pin();
    t_delay();
    t_back_to_back();
    tally_and_finish();
  end
endmodule // global_sync_control_bench
